// ===== hdl/mrc_pkg.sv
/*
 * Constants, register layout and state codes for the mode and reset controller.
 * Assumes a single 100 MHz clock that stands in for the on-chip oscillator.
 */
package mrc_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS      = 10;
    localparam int DEB_SHORT_NS       = 2_000_000;
    localparam int DEB_LONG_NS        = 16_000_000;
    localparam int WAKE_FILTER_NS     = 1_000;
    // Least times, rounded up to whole cycles
    localparam int DEB_SHORT_CYCLES   = (DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_LONG_CYCLES    = (DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_FILTER_CYCLES = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CLOCKS_SHORT   = 64;
    localparam int POR_CLOCKS_LONG    = 128;

    // ************************************************************
    // Counter widths
    // ************************************************************
    localparam int DEB_W              = 21;
    localparam int CS_W               = 8;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam int          GUARD_BIT     = 0;
    localparam int          SLEEP_BIT     = 1;
    localparam int          DEB_LONG_BIT  = 2;
    localparam int          WD_OFF_BIT    = 3;
    localparam logic        CTRL_RESET    = 1'b0;
    localparam int          ST_MODE_LSB   = 0;
    localparam int          ST_SYSRST_BIT = 6;
    localparam int          ST_PIN_BIT    = 7;
    localparam int          ST_PORTA_BIT  = 8;
    localparam int          ST_OSC_BIT    = 9;
    localparam int          ST_WD_BIT     = 10;
    localparam logic [3:0]  PA_MASK_DEF   = 4'h3;

    // ************************************************************
    // Mode states
    // ************************************************************
    typedef enum logic [5:0] {
        ST_POR     = 6'h01,
        ST_ACTIVE  = 6'h02,
        ST_STANDBY = 6'h04,
        ST_SLEEP   = 6'h08,
        ST_WAKE    = 6'h10,
        ST_HOLD    = 6'h20
    } mrc_state_type;

endpackage : mrc_pkg

// ===== hdl/mrc_mode_reset_ctrl.sv
/*
 * Operating mode and system reset controller: standby, guarded sleep,
 * reset merging and the strobe/reset pin, with an APB register slave.
 * Assumes the CPU and watchdog share clk_i;
 * the reset pin, port A and the monitor output arrive asynchronously.
 */
//
// Behaviour
// (RULE_01) A halt instruction puts the device into standby.
// (RULE_02) Standby stops only the instruction clock; oscillator and peripherals keep running.
// (RULE_03) Registers, RAM and pins keep their values throughout standby.
// (RULE_04) Standby ends on any reset or an enabled interrupt request.
// (RULE_05) Sleep request write is accepted only when the guard bit is already one.
// (RULE_06) Sleep stops the oscillator; only regulator and reset input stay alive.
// (RULE_07) Only the reset pin, held high at least 2 us, ends sleep; the code filters it for 1 us (WAKE_FILTER_NS).
// (RULE_08) Wake holds reset for the cold start period with strobe high.
// (RULE_09) Wake clears the sleep request flag but keeps the guard bit.
// (RULE_10) Guard reads zero after power-up and one after a wake; the code keeps the guard bit of the sleep write, which may be zero.
// (RULE_11) Reset comes from power-on, reset pin, port A combination, watchdog.
// (RULE_12) Strobe/reset output is high while any reset holds the system.
// (RULE_13) Reset when a build-time subset of port A inputs is all high.
// (RULE_14) Power-on holds reset for the first 64 or 128 clocks.
// (RULE_15) Oscillator stop outside sleep after power-up raises reset and strobe.
// (RULE_16) Reset pin is active high; undriven it reads inactive.
// (RULE_17) Watchdog reset is a software option that can be switched off.
// (RULE_18) A write to ports B, C or D pulses the strobe/reset output.
// (RULE_19) Outside sleep the reset pin must stay high for the debounce time.
// (RULE_20) Port A combination is debounced likewise and ignored during sleep.
// (RULE_21) The power-on clock count is a build-time parameter.
`timescale 1ns/100ps
module mrc_mode_reset_ctrl #(
    parameter int         DEB_SHORT   = mrc_pkg::DEB_SHORT_CYCLES,
    parameter int         DEB_LONG    = mrc_pkg::DEB_LONG_CYCLES,
    parameter int         POR_CLOCKS  = mrc_pkg::POR_CLOCKS_SHORT,
    parameter logic [3:0] PA_MASK     = mrc_pkg::PA_MASK_DEF
) (
    // Clock and power-up reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // APB slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [mrc_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic      [31:0]                prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // CPU core side
    input  wire logic                       halt_i,
    input  wire logic                       irq_i,
    input  wire logic                       port_write_i,
    input  wire logic                       wd_timeout_i,
    // Pins and analogue monitor
    input  wire logic                       reset_pin_i,
    input  wire logic [3:0]                 port_a_i,
    input  wire logic                       osc_stop_i,
    // Mode outputs
    output logic                            cpu_clk_en_o,
    output logic                            osc_run_o,
    output logic                            periph_run_o,
    output logic                            standby_o,
    output logic                            sleep_o,
    output logic                            sys_reset_o,
    output logic                            strobe_reset_o
);
    import mrc_pkg::*;
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic in_reset(input mrc_state_type s);
        return (s == ST_POR) || (s == ST_WAKE) || (s == ST_HOLD);
    endfunction : in_reset

    function automatic logic [DEB_W-1:0] deb_limit(input logic long_sel, input logic asleep);
        logic [DEB_W-1:0] lim;
        lim = long_sel ? DEB_W'(DEB_LONG) : DEB_W'(DEB_SHORT);
        if (asleep) begin
            lim = DEB_W'(WAKE_FILTER_CYCLES);
        end
        return lim;
    endfunction : deb_limit

    // Saturating count; clamps when the limit shrinks on sleep entry
    function automatic logic [DEB_W-1:0] sat_inc(input logic [DEB_W-1:0] c, input logic [DEB_W-1:0] lim);
        return (c >= lim) ? lim : c + DEB_W'(1);
    endfunction : sat_inc
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic       pin_meta_reg;
    logic       pin_sync_reg;
    logic [3:0] pa_meta_reg;
    logic [3:0] pa_sync_reg;
    logic       osc_meta_reg;
    logic       osc_sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pa_meta_reg  <= 4'h0;
            pa_sync_reg  <= 4'h0;
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= reset_pin_i;
            pin_sync_reg <= pin_meta_reg;
            pa_meta_reg  <= port_a_i;
            pa_sync_reg  <= pa_meta_reg;
            osc_meta_reg <= osc_stop_i;
            osc_sync_reg <= osc_meta_reg;
        end
    end
    // ************************************************************
    // Registers and state
    // ************************************************************
    mrc_state_type    state_reg;
    mrc_state_type    state_next;
    logic             guard_reg;
    logic             guard_next;
    logic             sleep_req_reg;
    logic             sleep_req_next;
    logic             deb_long_reg;
    logic             deb_long_next;
    logic             wd_off_reg;
    logic             wd_off_next;
    logic [DEB_W-1:0] pin_cnt_reg;
    logic [DEB_W-1:0] pin_cnt_next;
    logic [DEB_W-1:0] pa_cnt_reg;
    logic [DEB_W-1:0] pa_cnt_next;
    logic [CS_W-1:0]  cs_cnt_reg;
    logic [CS_W-1:0]  cs_cnt_next;
    logic             strobe_reg;
    logic [31:0]      prdata_reg;
    logic [31:0]      prdata_next;
    // ************************************************************
    // Decode
    // ************************************************************
    wire logic             is_sleep     = (state_reg == ST_SLEEP);
    wire logic             is_active    = (state_reg == ST_ACTIVE);
    wire logic             is_standby   = (state_reg == ST_STANDBY);
    wire logic [DEB_W-1:0] cur_limit    = deb_limit(deb_long_reg, is_sleep);
    wire logic             hit_ctrl     = (paddr_i == CTRL_OFFSET);
    wire logic             hit_status   = (paddr_i == STATUS_OFFSET);
    wire logic             apb_access   = psel_i & penable_i;
    wire logic             apb_wr       = apb_access & pwrite_i & hit_ctrl & ~in_reset(state_reg);
    // (RULE_16) Pin high means reset
    wire logic             pin_high     = pin_sync_reg;
    // (RULE_13) Build-time port A subset
    wire logic             pa_combo     = (PA_MASK != 4'h0) && ((pa_sync_reg & PA_MASK) == PA_MASK);
    // (RULE_19) Pin debounced outside sleep
    wire logic             pin_done     = ~is_sleep & (pin_cnt_reg == cur_limit);
    // (RULE_07) Short filter only while asleep
    wire logic             wake_done    = is_sleep & (pin_cnt_reg == cur_limit);
    // (RULE_20) Combination debounced
    wire logic             pa_done      = (pa_cnt_reg == cur_limit);
    // (RULE_17) Watchdog reset can be switched off
    wire logic             wd_reset     = wd_timeout_i & ~wd_off_reg;
    // (RULE_15) Oscillator stop counts only after power-up, outside sleep
    wire logic             osc_reset    = osc_sync_reg & ~is_sleep & (state_reg != ST_POR);
    // (RULE_11) Merged reset sources
    wire logic             any_reset    = pin_done | pa_done | wd_reset | osc_reset;
    // (RULE_05) Guard must already be set
    wire logic             sleep_accept = apb_wr & pwdata_i[SLEEP_BIT] & guard_reg & is_active;
    // (RULE_21) Build-time clock count
    wire logic             cs_done      = (cs_cnt_reg == CS_W'(POR_CLOCKS - 1));
    // ************************************************************
    // Mode state machine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_POR: begin
                // (RULE_14) Count oscillator clocks, then run
                if (cs_done) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (any_reset) begin
                    state_next = ST_HOLD;
                end else if (sleep_accept) begin
                    state_next = ST_SLEEP;
                end else if (halt_i) begin
                    // (RULE_01) Halt enters standby
                    state_next = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                // (RULE_04) Reset or enabled interrupt ends standby
                if (any_reset) begin
                    state_next = ST_HOLD;
                end else if (irq_i) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_SLEEP: begin
                // (RULE_07) Only the reset pin wakes
                if (wake_done) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // (RULE_08) Cold start hold before running
                if (cs_done) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_HOLD: begin
                if (!any_reset) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
    end
    // ************************************************************
    // Counters
    // ************************************************************
    // Saturating debounce counters; a low input restarts them
    always_comb begin
        pin_cnt_next = '0;
        if (pin_high) begin
            pin_cnt_next = sat_inc(pin_cnt_reg, cur_limit);
        end
        // (RULE_20) Combination ignored in sleep
        pa_cnt_next = '0;
        if (pa_combo && !is_sleep) begin
            pa_cnt_next = sat_inc(pa_cnt_reg, cur_limit);
        end
        cs_cnt_next = '0;
        if ((state_reg == ST_POR || state_reg == ST_WAKE) && !cs_done) begin
            cs_cnt_next = cs_cnt_reg + CS_W'(1);
        end
    end
    // ************************************************************
    // Control register
    // ************************************************************
    always_comb begin
        guard_next     = guard_reg;
        sleep_req_next = sleep_req_reg;
        deb_long_next  = deb_long_reg;
        wd_off_next    = wd_off_reg;
        if (apb_wr) begin
            guard_next    = pwdata_i[GUARD_BIT];
            deb_long_next = pwdata_i[DEB_LONG_BIT];
            wd_off_next   = pwdata_i[WD_OFF_BIT];
        end
        if (sleep_accept) begin
            sleep_req_next = 1'b1;
        end
        // (RULE_09) Wake drops the request, keeps the guard
        if (state_next == ST_WAKE || state_next == ST_HOLD) begin
            sleep_req_next = CTRL_RESET;
            deb_long_next  = CTRL_RESET;
            wd_off_next    = CTRL_RESET;
        end
        // (RULE_10) Any other reset clears the guard
        if (state_next == ST_HOLD) begin
            guard_next     = CTRL_RESET;
        end
    end
    // ************************************************************
    // APB read data
    // ************************************************************
    // Captured in the setup cycle so the read value comes from a flop
    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_ctrl) begin
            prdata_next[GUARD_BIT]    = guard_next;
            prdata_next[SLEEP_BIT]    = sleep_req_next;
            prdata_next[DEB_LONG_BIT] = deb_long_next;
            prdata_next[WD_OFF_BIT]   = wd_off_next;
        end else if (hit_status) begin
            prdata_next[ST_MODE_LSB +: 6] = state_reg;
            prdata_next[ST_SYSRST_BIT]    = in_reset(state_reg);
            prdata_next[ST_PIN_BIT]       = pin_done;
            prdata_next[ST_PORTA_BIT]     = pa_done;
            prdata_next[ST_OSC_BIT]       = osc_sync_reg;
            prdata_next[ST_WD_BIT]        = wd_timeout_i;
        end
    end
    // ************************************************************
    // Sequential state
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg     <= ST_POR;
            guard_reg     <= CTRL_RESET;
            sleep_req_reg <= CTRL_RESET;
            deb_long_reg  <= CTRL_RESET;
            wd_off_reg    <= CTRL_RESET;
            pin_cnt_reg   <= '0;
            pa_cnt_reg    <= '0;
            cs_cnt_reg    <= '0;
            strobe_reg    <= 1'b1;
            prdata_reg    <= 32'h0000_0000;
        end else begin
            state_reg     <= state_next;
            guard_reg     <= guard_next;
            sleep_req_reg <= sleep_req_next;
            deb_long_reg  <= deb_long_next;
            wd_off_reg    <= wd_off_next;
            pin_cnt_reg   <= pin_cnt_next;
            pa_cnt_reg    <= pa_cnt_next;
            cs_cnt_reg    <= cs_cnt_next;
            // (RULE_12) Strobe high in reset; (RULE_18) pulse on port write
            strobe_reg    <= in_reset(state_next) | port_write_i;
            if (psel_i && !penable_i) begin
                prdata_reg <= prdata_next;
            end
        end
    end
    // ************************************************************
    // Outputs
    // ************************************************************
    // (RULE_02) Standby gates only the instruction clock
    // (RULE_03) CPU stopped, so nothing it owns can change
    assign cpu_clk_en_o   = is_active;
    // (RULE_06) Sleep stops oscillator and peripherals
    assign osc_run_o      = ~is_sleep;
    assign periph_run_o   = ~is_sleep;
    assign standby_o      = is_standby;
    assign sleep_o        = is_sleep;
    assign sys_reset_o    = in_reset(state_reg);
    assign strobe_reset_o = strobe_reg;
    assign pready_o       = 1'b1;
    assign pslverr_o      = apb_access & ~(hit_ctrl | hit_status);
    assign prdata_o       = prdata_reg;
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_halt_standby;
        is_active && halt_i && !any_reset && !sleep_accept |=> standby_o && !cpu_clk_en_o;
    endproperty
    a_halt_standby: assert property (p_halt_standby) else $error("halt did not enter standby"); // RULE_01
    property p_standby_clocks;
        standby_o |-> !cpu_clk_en_o && osc_run_o && periph_run_o && !sys_reset_o;
    endproperty
    a_standby_clocks: assert property (p_standby_clocks) else $error("standby clock gating wrong"); // RULE_02
    property p_standby_irq;
        standby_o && irq_i && !any_reset |=> cpu_clk_en_o;
    endproperty
    a_standby_irq: assert property (p_standby_irq) else $error("interrupt did not end standby"); // RULE_04
    property p_guard_needed;
        apb_wr && pwdata_i[SLEEP_BIT] && !guard_reg |=> !sleep_o;
    endproperty
    a_guard_needed: assert property (p_guard_needed) else $error("sleep entered without guard"); // RULE_05
    property p_sleep_entry;
        sleep_accept && !any_reset |=> sleep_o && !osc_run_o && !cpu_clk_en_o;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("guarded sleep write not honoured"); // RULE_06
    property p_wake_hold;
        $fell(sleep_o) |-> sys_reset_o ##1 strobe_reset_o;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake without reset and strobe"); // RULE_08
    property p_wake_flags;
        $fell(sleep_o) |-> guard_reg && !sleep_req_reg;
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("wake flags wrong"); // RULE_09
    property p_strobe_follows;
        sys_reset_o |-> strobe_reset_o;
    endproperty
    a_strobe_follows: assert property (p_strobe_follows) else $error("strobe low during reset"); // RULE_12
    property p_porta_reset;
        pa_done && (is_active || is_standby) |=> sys_reset_o;
    endproperty
    a_porta_reset: assert property (p_porta_reset) else $error("port A combination ignored"); // RULE_13
    property p_por_length;
        $rose(cpu_clk_en_o) && $past(state_reg == ST_POR) |-> $past(cs_cnt_reg) == CS_W'(POR_CLOCKS - 1);
    endproperty
    a_por_length: assert property (p_por_length) else $error("power-on hold length wrong"); // RULE_14
    property p_wd_off;
        is_active && wd_timeout_i && wd_off_reg && !pin_done && !pa_done && !osc_reset |=> !sys_reset_o;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("disabled watchdog caused reset"); // RULE_17
    property p_port_strobe;
        port_write_i |=> strobe_reset_o;
    endproperty
    a_port_strobe: assert property (p_port_strobe) else $error("port write gave no strobe"); // RULE_18
    c_sleep_wake: cover property (sleep_o ##[1:1000] $fell(sleep_o));
    c_standby_exit: cover property (standby_o ##1 cpu_clk_en_o);
    c_pin_hold: cover property (is_active ##1 state_reg == ST_HOLD);
    c_port_pulse: cover property (is_active && port_write_i ##1 strobe_reset_o);

endmodule : mrc_mode_reset_ctrl

// ===== bench/mrc_pin_model.sv
/*
 * Board-side reset pin driver for the mode and reset controller bench.
 * Assumes go_i is a one-cycle request from the bench, on clk_i.
 */
`timescale 1ns/100ps
module mrc_pin_model (
    // Request from the bench
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [15:0] len_i,
    // Reset pin
    output logic             pin_o
);
    logic [15:0] cnt_reg;
    initial cnt_reg = 16'h0;
    always @(posedge clk_i) begin
        if (go_i)
            cnt_reg <= len_i;
        else if (cnt_reg != 16'h0)
            cnt_reg <= cnt_reg - 16'h1;
    end
    // released pin falls to pull-down level
    assign pin_o = (cnt_reg != 16'h0);
endmodule : mrc_pin_model

// ===== bench/tb.sv
/*
 * Self-checking bench for the mode and reset controller.
 * Assumes short debounce counts (250/400 cycles) to keep the run brief;
 * the short count stays above the 200-cycle wake pulse.
 */
`timescale 1ns/100ps
module tb;
    import mrc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, go = 1'b0;
    logic halt_i = 1'b0, irq_i = 1'b0, port_write_i = 1'b0, wd_timeout_i = 1'b0, osc_stop_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [3:0]  port_a_i = 4'h0;
    logic [15:0] len = 16'h0;
    logic reset_pin_i, pready_o, pslverr_o, err, hit, cpu_clk_en_o, osc_run_o, periph_run_o;
    logic standby_o, sleep_o, sys_reset_o, strobe_reset_o;
    logic [3:0]  c_t [4] = '{4'h0, 4'h0, 4'h4, 4'h4};
    logic [15:0] l_t [4] = '{16'h96, 16'h12c, 16'h12c, 16'h1f4};
    logic        e_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int mismatches = 0, tests_run = 0, cyc = 0, n;
    mrc_mode_reset_ctrl #(.DEB_SHORT(250), .DEB_LONG(400), .POR_CLOCKS(POR_CLOCKS_SHORT)) dut_u (
        .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .halt_i, .irq_i, .port_write_i, .wd_timeout_i, .reset_pin_i, .port_a_i, .osc_stop_i,
        .cpu_clk_en_o, .osc_run_o, .periph_run_o, .standby_o, .sleep_o, .sys_reset_o, .strobe_reset_o);
    mrc_pin_model pin_u (.clk_i(clk_i), .go_i(go), .len_i(len), .pin_o(reset_pin_i));
    always #5 clk_i = ~clk_i;
    // Hang guard, well above the expected run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1 || penable_i !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // Window watch: reset seen only if strobe is high with it
    task automatic watch(input int k, output logic h);
        h = 1'b0;
        repeat (k) begin
            @(posedge clk_i);
            #1;
            if (sys_reset_o === 1'b1 && strobe_reset_o === 1'b1)
                h = 1'b1;
        end
    endtask : watch
    task automatic settle;
        int k;
        k = 0;
        while (sys_reset_o !== 1'b0 && k < 800) begin
            @(posedge clk_i);
            #1;
            k++;
        end
    endtask : settle
    task automatic pulse(input logic [15:0] l);
        @(posedge clk_i);
        go <= 1'b1;
        len <= l;
        @(posedge clk_i);
        go <= 1'b0;
    endtask : pulse
    initial begin
        void'($urandom(68));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk({sys_reset_o, strobe_reset_o, cpu_clk_en_o}, 32'h6);
        n = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (cpu_clk_en_o !== 1'b1 && n < 300);
        chk(n, POR_CLOCKS_SHORT);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd[1:0], 32'h0);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        @(posedge clk_i);
        halt_i <= 1'b1;
        @(posedge clk_i);
        halt_i <= 1'b0;
        #1;
        chk({cpu_clk_en_o, osc_run_o, periph_run_o, standby_o}, 32'h7);
        @(posedge clk_i);
        irq_i <= 1'b1;
        @(posedge clk_i);
        irq_i <= 1'b0;
        #1;
        chk({cpu_clk_en_o, standby_o}, 32'h2);
        // Random port A values that never complete the combination
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            port_a_i <= 4'($urandom()) & ((i % 2 == 1) ? 4'hd : 4'he);
            watch(30, hit);
            chk(hit, 32'h0);
        end
        @(posedge clk_i);
        port_a_i <= 4'h3 | 4'($urandom());
        watch(300, hit);
        @(posedge clk_i);
        port_a_i <= 4'h0;
        chk(hit, 32'h1);
        settle();
        @(posedge clk_i);
        port_write_i <= 1'b1;
        @(posedge clk_i);
        port_write_i <= 1'b0;
        n = 0;
        repeat (4) begin
            #1;
            n += int'(strobe_reset_o === 1'b1);
            @(posedge clk_i);
        end
        chk(n, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, CTRL_OFFSET, {28'h0, c_t[i]});
            pulse(l_t[i]);
            watch(int'(l_t[i]) + 60, hit);
            chk(hit, {31'h0, e_t[i]});
            settle();
        end
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd[0], 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h8);
        @(posedge clk_i);
        wd_timeout_i <= 1'b1;
        watch(20, hit);
        chk(hit, 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h0);
        watch(10, hit);
        @(posedge clk_i);
        wd_timeout_i <= 1'b0;
        chk(hit, 32'h1);
        settle();
        @(posedge clk_i);
        osc_stop_i <= 1'b1;
        watch(10, hit);
        @(posedge clk_i);
        osc_stop_i <= 1'b0;
        chk(hit, 32'h1);
        settle();
        apb(1'b1, CTRL_OFFSET, 32'h2);
        repeat (2) @(posedge clk_i);
        #1;
        chk(sleep_o, 32'h0);
        apb(1'b1, CTRL_OFFSET, 32'h1);
        apb(1'b1, CTRL_OFFSET, 32'h3);
        repeat (2) @(posedge clk_i);
        #1;
        chk({sleep_o, osc_run_o, periph_run_o, cpu_clk_en_o}, 32'h8);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h8);
        pulse(16'hc8);
        watch(300, hit);
        chk(hit, 32'h1);
        settle();
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd[1:0], 32'h1);
        complete_run();
    end
endmodule : tb
